// ===== hw/hscb_top.sv
/*
  hscb_top: event flags, mask and interrupt, received crc capture and
  transmit byte counter of one hdlc controller.
  assumes: parallel port strobes and datapath events are synchronous to
  i_clk and one cycle wide; threshold inputs are levels.
*/
// What this block does
// - go-ahead pattern seen by receiver sets flag bit 7.
// - receiver writing an end-of-packet byte sets flag bit 6.
// - closing flag sent or packet aborted sets flag bit 5.
// - last byte at rx head, or empty rx read, sets bit 4.
// - tx fifo dropping below low threshold sets flag bit 3.
// - select high: transmitter reading an empty tx fifo sets bit 2.
// - rx fifo rising above full threshold sets flag bit 1.
// - write attempt into full 128-byte rx fifo sets flag bit 0.
// - overflow disables the receiver; the next flag re-enables it.
// - reading the flag register clears its bits.
// - upper received crc byte held in its read-only register.
// - lower received crc byte held in a second read-only register.
// - crc stored as received: msb first, inverted, uncorrected.
// - both crc registers updated at each packet end.
// - byte counter at one tags the next tx fifo write as packet end.
// - counter decrements after each tx fifo write, holding at zero.
// - with cycle set the counter reloads its programmed value.
// - flags set even when masked; masked flags never assert interrupt.
// - bit 7 of control register 2 selects underrun or abort.
`timescale 1ns/100ps
module hscb_top #(
  parameter int RX_DEPTH = hscb_pkg::HSCB_RX_FIFO_DEPTH,
  parameter int ABORT_MIN = hscb_pkg::HSCB_ABORT_MIN_BITS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // microprocessor port
  input wire hscb_pkg::hscb_bus_s i_bus,
  output logic [7:0] o_rdata,
  output logic o_rd_ack,
  // hdlc datapath
  input wire hscb_pkg::hscb_evt_s i_evt,
  input wire logic [7:0] i_rx_fifo_count,
  input wire logic [15:0] i_rx_crc,
  input wire logic i_rx_crc_valid,
  // controls back to the datapath
  output logic o_rx_enable,
  output logic o_tx_eop_tag,
  // interrupt
  output logic o_irq_n
);

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  function automatic logic hit(input hscb_pkg::hscb_bus_s b, input logic [7:0] a);
    hit = (b.addr == a);
  endfunction

  logic wr_ctrl2, wr_mask, wr_tx_length_count, rd_flags;

  // write and read-side-effect strobes
  always_comb begin
    wr_ctrl2 = i_bus.wr && hit(i_bus, hscb_pkg::HSCB_ADDR_CTRL2);
    wr_mask = i_bus.wr && hit(i_bus, hscb_pkg::HSCB_ADDR_MASK);
    wr_tx_length_count = i_bus.wr && hit(i_bus, hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT);
    rd_flags = i_bus.rd && hit(i_bus, hscb_pkg::HSCB_ADDR_FLAGS);
  end

  // ----------------------------------------------------------------
  // control and mask registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic intsel, cycle;

  // software writes
  always_comb begin
    ctrl2_nxt = wr_ctrl2 ? i_bus.wdata : ctrl2_r;
    mask_nxt = wr_mask ? i_bus.wdata : mask_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl2_r <= hscb_pkg::HSCB_RST_BYTE;
      mask_r <= hscb_pkg::HSCB_RST_BYTE;
    end else begin
      ctrl2_r <= ctrl2_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign intsel = ctrl2_r[hscb_pkg::HSCB_CTRL2_INTSEL];
  assign cycle = ctrl2_r[hscb_pkg::HSCB_CTRL2_CYCLE];

  // ----------------------------------------------------------------
  // receive bit count for abort qualification
  // ----------------------------------------------------------------
  localparam int BW = $clog2(ABORT_MIN + 1);
  localparam logic [BW-1:0] BITS_MIN = BW'(ABORT_MIN);
  logic [BW-1:0] bits_r, bits_nxt;
  logic long_enough;

  // restart at each flag, saturate at the minimum
  always_comb begin
    bits_nxt = bits_r;
    if (i_evt.rx_flag) begin
      bits_nxt = '0;
    end else if (i_evt.rx_bit && bits_r != BITS_MIN) begin
      bits_nxt = bits_r + BW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bits_r <= '0;
    end else begin
      bits_r <= bits_nxt;
    end
  end

  assign long_enough = (bits_r == BITS_MIN);

  // ----------------------------------------------------------------
  // threshold edges, overflow and receiver enable
  // ----------------------------------------------------------------
  logic tx_low_d_r, rx_high_d_r;
  logic rx_en_r, rx_en_nxt;
  logic ovf;

  // write attempt while all locations hold data
  assign ovf = i_evt.rx_write_try && (i_rx_fifo_count == 8'(RX_DEPTH));

  // overflow stops the receiver until the next flag
  always_comb begin
    rx_en_nxt = rx_en_r;
    if (ovf) begin
      rx_en_nxt = 1'b0;
    end else if (i_evt.rx_flag) begin
      rx_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_low_d_r <= 1'b0;
      rx_high_d_r <= 1'b0;
      rx_en_r <= 1'b1;
    end else begin
      tx_low_d_r <= i_evt.tx_below_low;
      rx_high_d_r <= i_evt.rx_above_full;
      rx_en_r <= rx_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  logic [7:0] set_vec;
  logic [7:0] flags_r, flags_nxt;

  // events mapped onto flag bits regardless of mask
  always_comb begin
    set_vec = '0;
    set_vec[hscb_pkg::HSCB_BIT_GO_AHEAD] = i_evt.go_ahead;
    set_vec[hscb_pkg::HSCB_BIT_RX_END] = i_evt.rx_eop_write;
    set_vec[hscb_pkg::HSCB_BIT_TX_DONE] = i_evt.tx_eop_sent;
    set_vec[hscb_pkg::HSCB_BIT_RX_LAST] = i_evt.rx_last_next
      || (i_evt.rx_fifo_read && i_evt.rx_fifo_empty);
    set_vec[hscb_pkg::HSCB_BIT_TX_LOW] = i_evt.tx_below_low && !tx_low_d_r;
    set_vec[hscb_pkg::HSCB_BIT_ABORT_UNDER] = intsel ? i_evt.tx_empty_read
      : (i_evt.rx_abort && long_enough);
    set_vec[hscb_pkg::HSCB_BIT_RX_HIGH] = i_evt.rx_above_full && !rx_high_d_r;
    set_vec[hscb_pkg::HSCB_BIT_RX_OVF] = ovf;
  end

  // clear on read; a set in the same cycle wins
  always_comb begin
    flags_nxt = (rd_flags ? 8'h00 : flags_r) | set_vec;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_r <= hscb_pkg::HSCB_RST_BYTE;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // received crc capture
  // ----------------------------------------------------------------
  logic [7:0] crc_hi_r, crc_hi_nxt, crc_lo_r, crc_lo_nxt;

  // bits kept exactly as sent, overwritten at each packet end
  always_comb begin
    crc_hi_nxt = i_rx_crc_valid ? i_rx_crc[15:8] : crc_hi_r;
    crc_lo_nxt = i_rx_crc_valid ? i_rx_crc[7:0] : crc_lo_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      crc_hi_r <= hscb_pkg::HSCB_RST_BYTE;
      crc_lo_r <= hscb_pkg::HSCB_RST_BYTE;
    end else begin
      crc_hi_r <= crc_hi_nxt;
      crc_lo_r <= crc_lo_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transmit byte counter
  // ----------------------------------------------------------------
  logic [7:0] tx_length_count;
  logic txtag;

  hscb_tx_length_count #(
    .W(8)
  ) u_tx_length_count (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(wr_tx_length_count),
    .i_load_val(i_bus.wdata),
    .i_wr_done(i_evt.tx_fifo_write),
    .i_cycle(cycle),
    .o_count(tx_length_count),
    .o_tag(txtag)
  );

  // ----------------------------------------------------------------
  // read data, interrupt and output registers
  // ----------------------------------------------------------------
  logic [7:0] rdata_r, rdata_nxt;
  logic ack_r, irq_n_r, tag_r;

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        hscb_pkg::HSCB_ADDR_CTRL2: rdata_nxt = ctrl2_r;
        hscb_pkg::HSCB_ADDR_MASK: rdata_nxt = mask_r;
        hscb_pkg::HSCB_ADDR_FLAGS: rdata_nxt = flags_r;
        hscb_pkg::HSCB_ADDR_CRC_HI: rdata_nxt = crc_hi_r;
        hscb_pkg::HSCB_ADDR_CRC_LO: rdata_nxt = crc_lo_r;
        hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT: rdata_nxt = tx_length_count;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_r <= hscb_pkg::HSCB_RST_BYTE;
      ack_r <= 1'b0;
      irq_n_r <= 1'b1;
      tag_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r <= i_bus.rd;
      irq_n_r <= ~|(flags_r & mask_r);
      tag_r <= txtag;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rd_ack = ack_r;
  assign o_irq_n = irq_n_r;
  assign o_rx_enable = rx_en_r;
  assign o_tx_eop_tag = tag_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_status_read;
    i_bus.rd && i_bus.addr == hscb_pkg::HSCB_ADDR_FLAGS;
  endsequence

  sequence s_irq_low_then;
    ##1 !o_irq_n;
  endsequence

  a_go_ahead_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_evt.go_ahead |=> flags_r[7])
    else $error("go-ahead did not set flag 7");

  a_rx_end_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_evt.rx_eop_write |=> flags_r[6])
    else $error("rx end of packet did not set flag 6");

  a_short_abort: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_evt.rx_abort && !intsel && !long_enough && !flags_r[2]) |=> !flags_r[2])
    else $error("abort before 26 bits was not ignored");

  a_long_abort: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_evt.rx_abort && !intsel && bits_r == BW'(ABORT_MIN)) |=> flags_r[2])
    else $error("abort after 26 bits did not set flag 2");

  a_underrun_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (intsel && i_evt.tx_empty_read) |=> flags_r[2])
    else $error("underrun did not set flag 2");

  a_overflow_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_evt.rx_write_try && i_rx_fifo_count == 8'h80) |=> flags_r[0] && !o_rx_enable)
    else $error("overflow did not flag and stop the receiver");

  a_flag_reenable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!o_rx_enable && i_evt.rx_flag && !i_evt.rx_write_try) |=> o_rx_enable)
    else $error("receiver not re-enabled by flag");

  a_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_status_read ##0 !i_evt.go_ahead) |=> !flags_r[7])
    else $error("status read did not clear flag 7");

  a_crc_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rx_crc_valid |=> {crc_hi_r, crc_lo_r} == $past(i_rx_crc))
    else $error("crc bytes not captured at packet end");

  a_irq_unmasked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|(flags_r & mask_r)) |-> s_irq_low_then)
    else $error("unmasked flag did not pull interrupt low");

  a_irq_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mask_r == 8'h00) |=> o_irq_n)
    else $error("masked flags drove the interrupt");

endmodule

// ===== include/hscb_pkg.sv
/*
  hscb_pkg: constants and carrier types for the hdlc status, received-crc
  and transmit byte count block.
  assumes: included once ahead of every design file that names hscb_pkg.
*/
package hscb_pkg;

  // ----------------------------------------------------------------
  // register offsets on the parallel microprocessor port
  // ----------------------------------------------------------------
  localparam logic [7:0] HSCB_ADDR_CTRL2 = 8'h15;
  localparam logic [7:0] HSCB_ADDR_MASK = 8'h16;
  localparam logic [7:0] HSCB_ADDR_FLAGS = 8'h17;
  localparam logic [7:0] HSCB_ADDR_CRC_HI = 8'h18;
  localparam logic [7:0] HSCB_ADDR_CRC_LO = 8'h19;
  localparam logic [7:0] HSCB_ADDR_TX_LENGTH_COUNT = 8'h1A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HSCB_BIT_GO_AHEAD = 7;
  localparam int HSCB_BIT_RX_END = 6;
  localparam int HSCB_BIT_TX_DONE = 5;
  localparam int HSCB_BIT_RX_LAST = 4;
  localparam int HSCB_BIT_TX_LOW = 3;
  localparam int HSCB_BIT_ABORT_UNDER = 2;
  localparam int HSCB_BIT_RX_HIGH = 1;
  localparam int HSCB_BIT_RX_OVF = 0;
  localparam int HSCB_CTRL2_INTSEL = 7;
  localparam int HSCB_CTRL2_CYCLE = 6;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] HSCB_RST_BYTE = 8'h00;
  localparam int HSCB_RX_FIFO_DEPTH = 128;
  localparam int HSCB_ABORT_MIN_BITS = 26;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // one-cycle events and threshold levels from the hdlc datapath
  typedef struct packed {
    logic go_ahead;        // receiver saw go-ahead pattern
    logic rx_eop_write;    // receiver wrote an end-of-packet byte
    logic tx_eop_sent;     // closing flag sent or packet aborted
    logic rx_last_next;    // byte at rx fifo head ends a packet
    logic tx_below_low;    // level: tx fifo under low threshold
    logic rx_abort;        // abort sequence received
    logic tx_empty_read;   // transmitter read an empty tx fifo
    logic rx_above_full;   // level: rx fifo above full threshold
    logic rx_write_try;    // receiver tries to write rx fifo
    logic rx_bit;          // one packet bit received
    logic rx_flag;         // flag received
    logic rx_fifo_read;    // software read of the rx fifo
    logic rx_fifo_empty;   // level: rx fifo empty
    logic tx_fifo_write;   // software write to tx fifo completed
  } hscb_evt_s;

  // one access of the parallel port, strobes one cycle wide
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hscb_bus_s;

endpackage

// ===== hw/hscb_tx_length_count.sv
/*
  hscb_tx_length_count: transmit byte counter that tags the end-of-packet byte.
  assumes: load and write-done pulses are one clock wide and synchronous.
*/
`timescale 1ns/100ps
module hscb_tx_length_count #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_wr_done,
  input wire logic i_cycle,
  // state
  output logic [W-1:0] o_count,
  output logic o_tag
);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  logic [W-1:0] prog_r, prog_nxt;
  logic [W-1:0] count_r, count_nxt;

  // load, decrement after each write down to zero, reload when cycling
  always_comb begin
    prog_nxt = prog_r;
    count_nxt = count_r;
    if (i_load) begin
      prog_nxt = i_load_val;
      count_nxt = i_load_val;
    end else if (i_wr_done) begin
      if (count_r == ONE && i_cycle) begin
        count_nxt = prog_r;
      end else if (count_r != ZERO) begin
        count_nxt = count_r - ONE;
      end
    end
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prog_r <= ZERO;
      count_r <= ZERO;
    end else begin
      prog_r <= prog_nxt;
      count_r <= count_nxt;
    end
  end

  assign o_count = count_r;
  assign o_tag = (count_r == ONE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_last_write;
    !i_load && i_wr_done && count_r == ONE;
  endsequence

  a_count_decrement: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_load && i_wr_done && count_r > ONE) |=> count_r == $past(count_r) - ONE)
    else $error("byte count did not step down after a write");

  a_cycle_reload: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_last_write and i_cycle) |=> count_r == $past(prog_r))
    else $error("byte count not reloaded while cycling");

  a_noncycle_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_last_write and !i_cycle) |=> count_r == ZERO && !o_tag)
    else $error("tag still raised after the end-of-packet write");

endmodule

// ===== tb/hscb_mpu_model.sv
/*
  hscb_mpu_model: microprocessor on the parallel port, issuing single byte
  reads and writes.
  assumes: tasks are called from one bench process; the port answers a read
  with a one-cycle acknowledge.
*/
`timescale 1ns/100ps
module hscb_mpu_model (
  // clock
  input wire logic i_clk,
  // parallel port
  output hscb_pkg::hscb_bus_s o_bus,
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_ack
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // idle port: strobes low
  initial begin
    o_bus = '0;
  end

  // one write strobe; address and data scrambled once released
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge i_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // one read strobe; data taken with the acknowledge
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    @(posedge i_clk);
    o_bus <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: ~o_bus.wdata};
    @(posedge i_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~o_bus.wdata};
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rd_ack === 1'b1) begin
        data = i_rdata;
        ok = 1'b1;
      end else begin
        @(posedge i_clk);
      end
    end
  endtask
endmodule

// ===== tb/testbench.sv
/*
  testbench: self-checking bench for hscb_top, one task per scenario.
  assumes: hscb_pkg is compiled first; the microprocessor model drives the port.
*/
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [13:0] E_GA = 14'h2000;
  localparam logic [13:0] E_ABORT = 14'h0100;
  localparam logic [13:0] E_TRY = 14'h0020;
  localparam logic [13:0] E_BIT = 14'h0010;
  localparam logic [13:0] E_FLAG = 14'h0008;
  localparam logic [13:0] E_EMPTY_RD = 14'h0006;
  localparam logic [13:0] E_TXWR = 14'h0001;
  logic i_clk;
  logic i_rst_n;
  hscb_pkg::hscb_bus_s bus;
  hscb_pkg::hscb_evt_s evt;
  logic [7:0] rx_count;
  logic [15:0] rx_crc;
  logic rx_crc_valid;
  logic [7:0] rdata;
  logic rd_ack, rx_enable, tx_tag, irq_n;
  int num_errors;
  int checks;

  hscb_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata), .o_rd_ack(rd_ack),
    .i_evt(evt), .i_rx_fifo_count(rx_count), .i_rx_crc(rx_crc), .i_rx_crc_valid(rx_crc_valid),
    .o_rx_enable(rx_enable), .o_tx_eop_tag(tx_tag), .o_irq_n(irq_n));
  hscb_mpu_model mpu (.i_clk(i_clk), .o_bus(bus), .i_rdata(rdata), .i_rd_ack(rd_ack));

  // 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // register read and compare; a missing acknowledge ends the run
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
    logic [7:0] d;
    logic ok;
    mpu.reg_read(addr, d, ok);
    if (!ok) begin
      chk("read_ack", {7'h00, ok}, 8'h01);
      test_done();
    end else begin
      chk(name, d, exp);
    end
  endtask

  // one-cycle pulse on the chosen event lines
  task automatic pulse(input logic [13:0] v);
    @(posedge i_clk);
    evt <= evt | v;
    @(posedge i_clk);
    evt <= evt & ~v;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, unmapped place and quiet outputs
  task automatic t_reset();
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h00, "flags");
    rd(hscb_pkg::HSCB_ADDR_CRC_HI, 8'h00, "crc_hi");
    rd(hscb_pkg::HSCB_ADDR_CRC_LO, 8'h00, "crc_lo");
    rd(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h00, "count");
    rd(hscb_pkg::HSCB_ADDR_MASK, 8'h00, "mask");
    mpu.reg_write(8'h30, 8'hA5);
    rd(8'h30, 8'h00, "unmapped");
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    chk("rx_enable", {7'h00, rx_enable}, 8'h01);
    $display("t_reset done");
  endtask

  // each event sets its own flag, and a read clears all
  task automatic t_flags();
    logic [13:0] ev [8] = '{14'h0020, 14'h0040, 14'h0080, 14'h0200, 14'h0400, 14'h0800, 14'h1000, 14'h2000};
    mpu.reg_write(hscb_pkg::HSCB_ADDR_CTRL2, 8'h80);
    rd(hscb_pkg::HSCB_ADDR_CTRL2, 8'h80, "ctrl2");
    for (int i = 0; i < 8; i++) begin
      rx_count <= (i == 0) ? 8'h80 : 8'h10;
      pulse(ev[i]);
      rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h01 << i, "flag_set");
      rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h00, "flag_clear");
    end
    pulse(E_EMPTY_RD);
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h10, "empty_read");
    pulse(E_FLAG);
    $display("t_flags done");
  endtask

  // abort counts only after enough received bits
  task automatic t_abort();
    mpu.reg_write(hscb_pkg::HSCB_ADDR_CTRL2, 8'h00);
    pulse(E_FLAG);
    repeat (hscb_pkg::HSCB_ABORT_MIN_BITS - 1) pulse(E_BIT);
    pulse(E_ABORT);
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h00, "early_abort");
    pulse(E_FLAG);
    repeat (hscb_pkg::HSCB_ABORT_MIN_BITS) pulse(E_BIT);
    pulse(E_ABORT);
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h04, "abort");
    $display("t_abort done");
  endtask

  // overflow stops the receiver until the next flag
  task automatic t_ovf();
    rx_count <= 8'h80;
    pulse(E_TRY);
    #1 chk("rx_enable", {7'h00, rx_enable}, 8'h00);
    pulse(E_FLAG);
    #1 chk("rx_enable", {7'h00, rx_enable}, 8'h01);
    pulse(E_TRY | E_FLAG);
    #1 chk("rx_enable", {7'h00, rx_enable}, 8'h00);
    pulse(E_FLAG);
    #1 chk("rx_enable", {7'h00, rx_enable}, 8'h01);
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h01, "ovf_flag");
    rx_count <= 8'h10;
    $display("t_ovf done");
  endtask

  // unmasked flag pulls the interrupt low, masked one does not
  task automatic t_irq();
    mpu.reg_write(hscb_pkg::HSCB_ADDR_MASK, 8'h80);
    rd(hscb_pkg::HSCB_ADDR_MASK, 8'h80, "mask");
    pulse(E_GA);
    @(posedge i_clk);
    #1 chk("irq_n", {7'h00, irq_n}, 8'h00);
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h80, "ga_flag");
    @(posedge i_clk);
    #1 chk("irq_n", {7'h00, irq_n}, 8'h01);
    pulse(14'h1000);
    @(posedge i_clk);
    #1 chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd(hscb_pkg::HSCB_ADDR_FLAGS, 8'h40, "masked_flag");
    mpu.reg_write(hscb_pkg::HSCB_ADDR_MASK, 8'h00);
    $display("t_irq done");
  endtask

  // crc bytes captured as sent, replaced by the next packet
  task automatic t_crc();
    logic [15:0] v [2] = '{16'hA53C, 16'h0FF0};
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      rx_crc <= v[i];
      rx_crc_valid <= 1'b1;
      @(posedge i_clk);
      rx_crc <= ~v[i];
      rx_crc_valid <= 1'b0;
      mpu.reg_write(hscb_pkg::HSCB_ADDR_CRC_HI, 8'h55);
      rd(hscb_pkg::HSCB_ADDR_CRC_HI, v[i][15:8], "crc_hi");
      rd(hscb_pkg::HSCB_ADDR_CRC_LO, v[i][7:0], "crc_lo");
    end
    $display("t_crc done");
  endtask

  // byte counter down to the end tag, once and cycling
  task automatic t_tx_length_count();
    mpu.reg_write(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h03);
    rd(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h03, "count");
    chk("tag", {7'h00, tx_tag}, 8'h00);
    for (int n = 2; n >= 0; n--) begin
      pulse(E_TXWR);
      rd(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, n[7:0], "count");
      chk("tag", {7'h00, tx_tag}, (n == 1) ? 8'h01 : 8'h00);
    end
    pulse(E_TXWR);
    rd(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h00, "count_floor");
    mpu.reg_write(hscb_pkg::HSCB_ADDR_CTRL2, 8'h40);
    rd(hscb_pkg::HSCB_ADDR_CTRL2, 8'h40, "ctrl2");
    mpu.reg_write(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h02);
    pulse(E_TXWR);
    rd(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h01, "count");
    chk("tag", {7'h00, tx_tag}, 8'h01);
    pulse(E_TXWR);
    rd(hscb_pkg::HSCB_ADDR_TX_LENGTH_COUNT, 8'h02, "reload");
    mpu.reg_write(hscb_pkg::HSCB_ADDR_CTRL2, 8'h00);
    $display("t_tx_length_count done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    checks = 0;
    i_rst_n = 1'b0;
    evt = '0;
    rx_count = 8'h10;
    rx_crc = 16'h0000;
    rx_crc_valid = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_abort();
    t_ovf();
    t_irq();
    t_crc();
    t_tx_length_count();
    test_done();
  end
endmodule
